// *** rtl/svc_scaler_ctrl.sv ***
// Scaler input selection and vertical scaling control with AHB-Lite registers
// Notes on behaviour
// - Field memory mode offset: 0CH for ratio 1 and 2, 16H for 4, 2EH for 8.
// - Source select 00 takes whole stream from first port, 01 from second.
// - 10: luma second port, chroma first; 11 reversed; reference from chroma port.
// - Mirror bit flips lines; software keeps prescaled pixel count below 384.
// - Sync select bit picks sync, field and clock from first or second port.
// - Scaling starts at programmed line, counted in line events after vertical sync.
// - Arithmetic mode bit: clear is linear interpolation, set is accumulating filter.
// - Sequence length sets lines accumulated per output line; software keeps it consistent.
// - Odd fields start at the odd phase, phase times 128.
// - Even fields start at the even phase, same encoding.
`timescale 1ns/1ps
`include "svc_consts.svh"

module svc_scaler_ctrl #(
    parameter int LINE_MAX = `SVC_LINE_MAX
) (
    // Bus clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // Video ports, on the line-locked clock
    input  wire logic                  line_clk,
    input  wire svc_pkg::svc_port_t    port_a,
    input  wire svc_pkg::svc_port_t    port_b,
    // Clock mux steer and scaler stream
    output logic                       line_locked_clock_select,
    output svc_pkg::svc_video_t        video_out
);
    localparam int AW = $clog2(2 * LINE_MAX);

    ////////////////////////////////////////////////////////////////////////////
    // Register slave (hclk)
    logic [31:0]       src_reg;
    logic [31:0]       vert_reg;
    logic [4:0]        pre_reg;
    logic [31:0]       hrdata_reg;
    logic              wr_ph_reg;
    logic [7:0]        addr_reg;
    logic              dirty_reg;
    logic              req_tgl_reg;
    logic              ack_s1_reg;
    logic              ack_s2_reg;
    logic [1:0]        st_s1_reg;
    logic [1:0]        st_s2_reg;
    svc_pkg::svc_cfg_t xfer_reg;
    svc_pkg::svc_cfg_t cfg_now;
    logic              addr_ok;
    logic              busy;
    logic              launch;
    logic              cfg_wr;
    logic              ack_tgl_reg;
    logic [1:0]        stat_reg;
    logic              vs_edge;

    assign addr_ok   = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;
    assign line_locked_clock_select = src_reg[`SVC_SYNC_SEL_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_reg <= 1'b0;
            addr_reg  <= 8'h00;
        end else begin
            wr_ph_reg <= addr_ok & hwrite;
            addr_reg  <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_reg  <= `SVC_REG_RESET;
            vert_reg <= `SVC_REG_RESET;
            pre_reg  <= 5'h00;
        end else if (wr_ph_reg) begin
            if (addr_reg == `SVC_SRC_OFS) begin
                src_reg <= hwdata;
            end else if (addr_reg == `SVC_VERT_OFS) begin
                vert_reg <= hwdata;
            end else if (addr_reg == `SVC_PRE_OFS) begin
                pre_reg <= hwdata[`SVC_RATIO_HI:`SVC_RMODE_LO];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            if (haddr[7:0] == `SVC_SRC_OFS) begin
                hrdata_reg <= src_reg;
            end else if (haddr[7:0] == `SVC_VERT_OFS) begin
                hrdata_reg <= vert_reg;
            end else if (haddr[7:0] == `SVC_PRE_OFS) begin
                hrdata_reg <= {25'h0, pre_reg, 2'h0};
            end else if (haddr[7:0] == `SVC_STAT_OFS) begin
                hrdata_reg <= {29'h0, st_s2_reg, dirty_reg | busy};
            end else begin
                hrdata_reg <= 32'h0000_0000;
            end
        end
    end

    always_comb begin
        cfg_now            = '0;
        cfg_now.src_sel    = src_reg[`SVC_SRC_SEL_HI:`SVC_SRC_SEL_LO];
        cfg_now.mirror     = src_reg[`SVC_MIRROR_BIT];
        cfg_now.sync_sel   = src_reg[`SVC_SYNC_SEL_BIT];
        cfg_now.start_line = src_reg[`SVC_START_HI:`SVC_START_LO];
        cfg_now.arith_mode = vert_reg[`SVC_ARITH_BIT];
        cfg_now.incr       = vert_reg[`SVC_INCR_HI:`SVC_INCR_LO];
        cfg_now.acc_len    = vert_reg[`SVC_ACCLEN_HI:`SVC_ACCLEN_LO];
        cfg_now.odd_ph     = vert_reg[`SVC_ODD_HI:`SVC_ODD_LO];
        cfg_now.even_ph    = vert_reg[`SVC_EVEN_HI:`SVC_EVEN_LO];
        cfg_now.ratio      = pre_reg[4:2];
        cfg_now.field_mode = (pre_reg[1:0] == `SVC_RMODE_FIELD);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Settings handoff to the link domain
    // Toggle handshake: xfer_reg is frozen until the far side acknowledges
    assign busy   = req_tgl_reg ^ ack_s2_reg;
    assign launch = dirty_reg & ~busy;
    assign cfg_wr = wr_ph_reg & ((addr_reg == `SVC_SRC_OFS) | (addr_reg == `SVC_VERT_OFS)
                  | (addr_reg == `SVC_PRE_OFS));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dirty_reg   <= 1'b0;
            req_tgl_reg <= 1'b0;
            xfer_reg    <= '0;
        end else begin
            // A write in the launch cycle keeps the flag set
            dirty_reg <= cfg_wr | (dirty_reg & ~launch);
            if (launch) begin
                req_tgl_reg <= ~req_tgl_reg;
                xfer_reg    <= cfg_now;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
            st_s1_reg  <= 2'h0;
            st_s2_reg  <= 2'h0;
        end else begin
            ack_s1_reg <= ack_tgl_reg;
            ack_s2_reg <= ack_s1_reg;
            st_s1_reg  <= stat_reg;
            st_s2_reg  <= st_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain reset and settings capture
    logic              lrst_s1_reg;
    logic              lrst_n;
    logic              req_s1_reg;
    logic              req_s2_reg;
    logic              req_s3_reg;
    logic              pend_vld_reg;
    svc_pkg::svc_cfg_t pend_cfg_reg;
    svc_pkg::svc_cfg_t act_cfg;
    svc_pkg::svc_cfg_t nxt_cfg;
    logic              new_cfg;

    always_ff @(posedge line_clk or negedge hresetn) begin
        if (!hresetn) begin
            lrst_s1_reg <= 1'b0;
            lrst_n      <= 1'b0;
        end else begin
            lrst_s1_reg <= 1'b1;
            lrst_n      <= lrst_s1_reg;
        end
    end

    assign new_cfg = req_s2_reg ^ req_s3_reg;
    assign nxt_cfg = pend_vld_reg ? pend_cfg_reg : act_cfg;

    always_ff @(posedge line_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            req_s1_reg   <= 1'b0;
            req_s2_reg   <= 1'b0;
            req_s3_reg   <= 1'b0;
            ack_tgl_reg  <= 1'b0;
            pend_vld_reg <= 1'b0;
            pend_cfg_reg <= '0;
            act_cfg      <= '0;
        end else begin
            req_s1_reg  <= req_tgl_reg;
            req_s2_reg  <= req_s1_reg;
            req_s3_reg  <= req_s2_reg;
            ack_tgl_reg <= req_s2_reg;
            if (new_cfg) begin
                pend_cfg_reg <= xfer_reg;
            end
            pend_vld_reg <= new_cfg | (pend_vld_reg & ~vs_edge);
            if (vs_edge) begin
                act_cfg <= nxt_cfg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port selection
    svc_pkg::svc_port_t sy_port;
    svc_pkg::svc_port_t y_port;
    svc_pkg::svc_port_t c_port;
    logic               sel_chroma_reference;
    logic [7:0]         sel_byte;

    always_comb begin
        sy_port = act_cfg.sync_sel ? port_b : port_a;
        case (act_cfg.src_sel)
            2'h0: begin
                y_port = port_a;
                c_port = port_a;
            end
            2'h1: begin
                y_port = port_b;
                c_port = port_b;
            end
            2'h2: begin
                y_port = port_b;
                c_port = port_a;
            end
            default: begin
                y_port = port_a;
                c_port = port_b;
            end
        endcase
        sel_chroma_reference = c_port.chroma_reference;
        sel_byte = sel_chroma_reference ? c_port.data : y_port.data;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Vertical sequencing
    svc_pkg::svc_vstate_t state_reg;
    logic [11:0]          line_cnt_reg;
    logic [11:0]          acc_reg;
    logic [5:0]           seq_reg;
    logic                 vs_d_reg;
    logic                 hr_d_reg;
    logic [7:0]           px_d_reg;
    logic                 cr_d_reg;
    logic                 field_reg;
    logic                 keep_reg;
    logic                 line_on_reg;
    logic                 line_ev;
    logic                 line_end;
    logic                 take_line;
    logic                 emit;
    logic                 seq_last;

    assign vs_edge   = sy_port.vsync & ~vs_d_reg;
    assign line_ev   = sy_port.href & ~hr_d_reg;
    assign line_end  = ~sy_port.href & hr_d_reg;
    assign take_line = line_ev & ~vs_edge & ((state_reg == svc_pkg::VS_ACTIVE)
                     | ((state_reg == svc_pkg::VS_SKIP) & (line_cnt_reg == act_cfg.start_line)));
    assign seq_last  = ({1'b0, seq_reg} + 7'h01) >= {1'b0, act_cfg.acc_len};
    // interpolation emits when phase is under one line
    assign emit      = act_cfg.arith_mode ? seq_last : (acc_reg[11:10] == 2'h0);

    always_ff @(posedge line_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            vs_d_reg <= 1'b0;
            hr_d_reg <= 1'b0;
            px_d_reg <= 8'h00;
            cr_d_reg <= 1'b0;
        end else begin
            vs_d_reg <= sy_port.vsync;
            hr_d_reg <= sy_port.href;
            px_d_reg <= sel_byte;
            cr_d_reg <= sel_chroma_reference;
        end
    end

    always_ff @(posedge line_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            state_reg    <= svc_pkg::VS_WAIT;
            line_cnt_reg <= 12'h000;
            field_reg    <= 1'b0;
        end else if (vs_edge) begin
            state_reg    <= svc_pkg::VS_SKIP;
            line_cnt_reg <= 12'h000;
            field_reg    <= sy_port.field;
        end else if (line_ev) begin
            if (take_line) begin
                state_reg <= svc_pkg::VS_ACTIVE;
            end
            if (line_cnt_reg != 12'hfff) begin
                line_cnt_reg <= line_cnt_reg + 12'h001;
            end
        end
    end

    always_ff @(posedge line_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            acc_reg <= 12'h000;
            seq_reg <= 6'h00;
        end else if (vs_edge) begin
            // field start phase in 1/1024 steps
            acc_reg <= sy_port.field ? {2'h0, nxt_cfg.odd_ph, 3'h0} : {2'h0, nxt_cfg.even_ph, 3'h0};
            seq_reg <= 6'h00;
        end else if (take_line) begin
            if (act_cfg.arith_mode) begin
                seq_reg <= seq_last ? 6'h00 : seq_reg + 6'h01;
                acc_reg <= {2'h0, acc_reg[9:0] + act_cfg.incr};
            end else if (emit) begin
                acc_reg <= acc_reg + {2'h0, act_cfg.incr};
            end else begin
                acc_reg <= acc_reg - `SVC_PHASE_ONE;
            end
        end
    end

    always_ff @(posedge line_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            keep_reg    <= 1'b0;
            line_on_reg <= 1'b0;
        end else if (vs_edge || line_end) begin
            line_on_reg <= 1'b0;
        end else if (take_line) begin
            line_on_reg <= 1'b1;
            keep_reg    <= act_cfg.arith_mode | emit;
        end
    end

    always_ff @(posedge line_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            stat_reg <= 2'h0;
        end else begin
            stat_reg <= {state_reg == svc_pkg::VS_ACTIVE, field_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mirror line buffer
    // Mirroring shows the previous kept line reversed, one line late;
    // byte order inside a 4:2:2 pair is reversed too
    logic [7:0]        mem [0:2*LINE_MAX-1];
    logic              wbank_reg;
    logic [AW-1:0]     wptr_reg;
    logic [AW-1:0]     rptr_reg;
    logic [AW-1:0]     len_reg;
    logic [AW-1:0]     wr_addr;
    logic [AW-1:0]     rd_addr;
    logic [AW-1:0]     bank_ofs;
    logic              vld1;

    assign vld1     = hr_d_reg & line_on_reg & keep_reg;
    assign bank_ofs = AW'(LINE_MAX);
    assign wr_addr  = wbank_reg ? wptr_reg + bank_ofs : wptr_reg;
    assign rd_addr  = (wbank_reg ? AW'(0) : bank_ofs) + len_reg - rptr_reg - AW'(1);

    always_ff @(posedge line_clk) begin
        if (vld1 && wptr_reg < bank_ofs) begin
            mem[wr_addr] <= px_d_reg;
        end
    end

    always_ff @(posedge line_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            wbank_reg <= 1'b0;
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            len_reg   <= '0;
        end else if (take_line && (act_cfg.arith_mode || emit)) begin
            wbank_reg <= ~wbank_reg;
            len_reg   <= wptr_reg;
            wptr_reg  <= '0;
            rptr_reg  <= '0;
        end else if (vld1) begin
            // writes stop at the line limit
            if (wptr_reg < bank_ofs) begin
                wptr_reg <= wptr_reg + AW'(1);
            end
            if (rptr_reg < len_reg) begin
                rptr_reg <= rptr_reg + AW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stream output
    function automatic logic [7:0] hofs(input logic [2:0] ratio);
        case (ratio)
            3'h3:    hofs = `SVC_HOFS_R4;
            3'h7:    hofs = `SVC_HOFS_R8;
            default: hofs = `SVC_HOFS_R12;
        endcase
    endfunction

    always_ff @(posedge line_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            video_out <= '0;
        end else begin
            video_out.pixel     <= act_cfg.mirror ? mem[rd_addr] : px_d_reg;
            video_out.pix_valid <= vld1 & (~act_cfg.mirror | (rptr_reg < len_reg));
            video_out.is_chroma <= cr_d_reg;
            video_out.out_line  <= take_line & emit;
            video_out.phase     <= take_line ? acc_reg[9:3] : video_out.phase;
            video_out.hoffset   <= act_cfg.field_mode ? hofs(act_cfg.ratio) : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // offset for ratio eight
    chk_hofs_ratio8: assert property (@(posedge line_clk) disable iff (!lrst_n)
        act_cfg.field_mode && act_cfg.ratio == 3'h7 |=> video_out.hoffset == `SVC_HOFS_R8)
        else $error("field memory offset wrong for ratio eight");
    chk_src_whole: assert property (@(posedge line_clk) disable iff (!lrst_n)
        !act_cfg.src_sel[1] |-> sel_byte == (act_cfg.src_sel[0] ? port_b.data : port_a.data))
        else $error("whole stream source mismatch");
    chk_chroma_reference_port: assert property (@(posedge line_clk) disable iff (!lrst_n)
        act_cfg.src_sel[1] |-> sel_chroma_reference == (act_cfg.src_sel[0] ? port_b.chroma_reference : port_a.chroma_reference))
        else $error("chroma reference from wrong port");
    chk_mirror_off: assert property (@(posedge line_clk) disable iff (!lrst_n)
        vld1 && !act_cfg.mirror |=> video_out.pix_valid && video_out.pixel == $past(px_d_reg))
        else $error("unmirrored pixel not passed through");
    chk_sync_port: assert property (@(posedge line_clk) disable iff (!lrst_n)
        sy_port.vsync == (act_cfg.sync_sel ? port_b.vsync : port_a.vsync))
        else $error("sync taken from wrong port");
    chk_start_line: assert property (@(posedge line_clk) disable iff (!lrst_n)
        state_reg == svc_pkg::VS_SKIP && line_ev && !vs_edge
        && line_cnt_reg == act_cfg.start_line |=> state_reg == svc_pkg::VS_ACTIVE)
        else $error("scaling did not start at programmed line");
    chk_lpi_skip: assert property (@(posedge line_clk) disable iff (!lrst_n)
        take_line && !act_cfg.arith_mode && acc_reg >= `SVC_PHASE_ONE
        |=> !keep_reg && !video_out.out_line)
        else $error("interpolation kept a line past phase one");
    chk_acc_seq: assert property (@(posedge line_clk) disable iff (!lrst_n)
        take_line && act_cfg.arith_mode |=> keep_reg && video_out.out_line == $past(seq_last))
        else $error("accumulation sequence length not kept");
    chk_odd_phase: assert property (@(posedge line_clk) disable iff (!lrst_n)
        vs_edge && sy_port.field |=> acc_reg == {2'h0, $past(nxt_cfg.odd_ph), 3'h0})
        else $error("odd field start phase wrong");
    chk_even_phase: assert property (@(posedge line_clk) disable iff (!lrst_n)
        vs_edge && !sy_port.field |=> acc_reg == {2'h0, $past(nxt_cfg.even_ph), 3'h0})
        else $error("even field start phase wrong");
    chk_cfg_frozen: assert property (@(posedge line_clk) disable iff (!lrst_n)
        !vs_edge |=> $stable(act_cfg))
        else $error("settings changed outside vertical sync");
endmodule

// *** include/svc_consts.svh ***
// Register offsets, field positions, reset values and fixed counts of the scaler control
`ifndef SVC_CONSTS_SVH
`define SVC_CONSTS_SVH
`define SVC_SRC_OFS        8'h5c
`define SVC_VERT_OFS       8'h60
`define SVC_PRE_OFS        8'h68
`define SVC_STAT_OFS       8'h6c
`define SVC_REG_RESET      32'h0000_0000
`define SVC_SRC_SEL_HI     31
`define SVC_SRC_SEL_LO     30
`define SVC_MIRROR_BIT     29
`define SVC_SYNC_SEL_BIT   28
`define SVC_START_HI       23
`define SVC_START_LO       12
`define SVC_ARITH_BIT      31
`define SVC_INCR_HI        30
`define SVC_INCR_LO        21
`define SVC_ACCLEN_HI      20
`define SVC_ACCLEN_LO      15
`define SVC_ODD_HI         14
`define SVC_ODD_LO         8
`define SVC_EVEN_HI        7
`define SVC_EVEN_LO        1
`define SVC_RATIO_HI       6
`define SVC_RATIO_LO       4
`define SVC_RMODE_HI       3
`define SVC_RMODE_LO       2
`define SVC_RMODE_FIELD    2'h1
`define SVC_HOFS_R12       8'h0c
`define SVC_HOFS_R4        8'h16
`define SVC_HOFS_R8        8'h2e
`define SVC_PHASE_ONE      12'h400
`define SVC_LINE_MAX       384
`endif

// *** include/svc_pkg.sv ***
// Types shared by the scaler input and vertical control block
package svc_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic       href;
        logic       vsync;
        logic       field;
        logic       chroma_reference;
    } svc_port_t;

    typedef struct packed {
        logic [1:0]  src_sel;
        logic        mirror;
        logic        sync_sel;
        logic [11:0] start_line;
        logic        arith_mode;
        logic [9:0]  incr;
        logic [5:0]  acc_len;
        logic [6:0]  odd_ph;
        logic [6:0]  even_ph;
        logic [2:0]  ratio;
        logic        field_mode;
    } svc_cfg_t;

    typedef struct packed {
        logic [7:0] pixel;
        logic       pix_valid;
        logic       is_chroma;
        logic       out_line;
        logic [6:0] phase;
        logic [7:0] hoffset;
    } svc_video_t;

    typedef enum logic [1:0] {VS_WAIT, VS_SKIP, VS_ACTIVE} svc_vstate_t;
endpackage

// *** verif/svc_video_src.sv ***
// Video decoder model driving one port with short frames of short lines
`timescale 1ns/1ps
module svc_video_src #(
    parameter logic [7:0] SALT = 8'h00
) (
    // Link clock and reset
    input  wire logic          line_clk,
    input  wire logic          rst_n,
    // Port toward the scaler
    output svc_pkg::svc_port_t port
);
    int cyc;
    always_ff @(posedge line_clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc  <= 0;
            port <= '0;
        end else begin
            cyc        <= (cyc == 199) ? 0 : cyc + 1;
            port.vsync <= (cyc < 2);
            port.href  <= (cyc >= 10) && (cyc < 154) && ((cyc - 10) % 24 < 16);
            // Bytes change every cycle, so a stale byte never passes for a match
            port.data  <= cyc[7:0] ^ SALT;
            port.chroma_reference  <= cyc[0];
            if (cyc == 199) begin
                port.field <= ~port.field;
            end
        end
    end
endmodule

// *** verif/svc_scaler_ctrl_tb.sv ***
// Self-checking bench: registers, source routing, start line and offsets
`timescale 1ns/1ps
module svc_scaler_ctrl_tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, line_clk = 0, ck_en = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, w;
    logic [1:0] htrans = '0, cur_src = '0;
    logic hreadyout, hresp, llc_sel;
    svc_pkg::svc_port_t pa, pb, pa1, pa2, pb1, pb2;
    svc_pkg::svc_video_t vo;
    int n_mismatch = 0, check_count = 0, cycles = 0, pv_cnt = 0;
    // Qualified input lines per frame of the source model at start line 0
    localparam int N_IL = 6;
    int ol_cnt = 0, nl = 0;
    int lens [4] = '{1, 2, 3, 6};
    logic [6:0] ph_o = '0, ph_e = '0;
    logic [7:0] last_px = '0;
    logic ph_en = 0, mir_en = 0, pv_last = 0;
    logic [2:0] ratios [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    logic [7:0] offs [4] = '{8'h0c, 8'h0c, 8'h16, 8'h2e};
    always #5 hclk = ~hclk;
    initial begin
        #3.7;
        forever #24 line_clk = ~line_clk;
    end
    svc_scaler_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .line_clk(line_clk),
        .port_a(pa), .port_b(pb), .line_locked_clock_select(llc_sel), .video_out(vo));
    svc_video_src #(.SALT(8'h00)) src_a (.line_clk(line_clk), .rst_n(hresetn), .port(pa));
    svc_video_src #(.SALT(8'ha5)) src_b (.line_clk(line_clk), .rst_n(hresetn), .port(pb));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge hclk);
    endtask
    task automatic frames(input int n);
        repeat (n * 200) @(posedge line_clk);
        @(posedge hclk);
    endtask
    // Expected byte: C from the chroma port when its reference is high, else Y
    function automatic logic [8:0] exp_pix(logic [1:0] s, svc_pkg::svc_port_t a, b);
        svc_pkg::svc_port_t c, l;
        c = s[0] ? b : a;
        l = (s[1] ^ s[0]) ? b : a;
        return {c.chroma_reference, c.chroma_reference ? c.data : l.data};
    endfunction
    // Vertical word for N_IL input and nol output lines; phases zero in interpolation
    function automatic logic [31:0] vert_word(input bit am, input int nol, input logic [31:0] r);
        int inc;
        inc = am ? 1024 * (N_IL - nol) / N_IL : 1024 * (N_IL - nol) / nol;
        return {am, inc[9:0], am ? 6'(N_IL / nol) : r[5:0], am ? r[19:6] : 14'h0000, 1'b0};
    endfunction
    always @(posedge line_clk) begin
        pa1 <= pa;
        pa2 <= pa1;
        pb1 <= pb;
        pb2 <= pb1;
        if (vo.pix_valid === 1'b1) pv_cnt++;
        if (vo.out_line === 1'b1) ol_cnt++;
        if (ph_en && vo.out_line === 1'b1)
            chk({25'h0, vo.phase}, {25'h0, pa2.field ? ph_o : ph_e}, "start phase");
        if (mir_en && pv_last && vo.pix_valid === 1'b1)
            chk({24'h0, vo.pixel}, {24'h0, last_px - 8'h01}, "mirror order");
        pv_last <= vo.pix_valid;
        last_px <= vo.pixel;
        if (ck_en && vo.pix_valid === 1'b1)
            chk({23'h0, vo.is_chroma, vo.pixel}, {23'h0, exp_pix(cur_src, pa2, pb2)}, "pix");
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(54));
        repeat (12) @(posedge hclk);
        hresetn <= 1;
        bus(0, 8'h5c, 0); chk(rd, 0, "reset src");
        bus(0, 8'h74, 0); chk(rd, 0, "unmapped");
        repeat (4) begin
            w = $urandom();
            bus(1, 8'h60, w);
            bus(0, 8'h60, 0); chk(rd, w, "vert rw");
        end
        bus(1, 8'h60, 0);
        for (int s = 0; s < 4; s++) begin
            ck_en = 0;
            w = $urandom();
            w = {s[1:0], 1'b0, w[0], w[7:4], 12'h000, w[19:8]};
            bus(1, 8'h5c, w);
            chk({31'h0, llc_sel}, {31'h0, w[28]}, "clk sel");
            frames(2);
            cur_src = s[1:0];
            ck_en = 1;
            frames(1);
        end
        ck_en = 0;
        bus(1, 8'h5c, 32'h0000_7000);
        frames(2);
        pv_cnt = 0;
        frames(1);
        chk(pv_cnt, 0, "start past lines");
        bus(1, 8'h5c, 32'h0000_5000);
        frames(2);
        pv_cnt = 0;
        frames(1);
        chk(pv_cnt, 16, "start line 5");
        for (int i = 0; i < 5; i++) begin
            bus(1, 8'h68, (i < 4) ? {25'h0, ratios[i], 4'h4} : 32'h70);
            frames(2);
            chk({24'h0, vo.hoffset}, (i < 4) ? {24'h0, offs[i]} : 0, "hoffset");
        end
        // Only line 5 is taken, so its phase is the field's start phase
        ph_o = 7'($urandom());
        ph_e = 7'($urandom());
        w = $urandom();
        bus(1, 8'h60, {1'b0, w[30:15], ph_o, ph_e, 1'b0});
        frames(2);
        ph_en = 1;
        frames(2);
        ph_en = 0;
        bus(1, 8'h5c, 0);
        for (int m = 0; m < 4; m++) begin
            nl = (m == 0) ? N_IL : (m == 1) ? 4 : N_IL / lens[$urandom() % 4];
            w = $urandom();
            bus(1, 8'h60, vert_word(m > 1, nl, w));
            frames(2);
            ol_cnt = 0;
            frames(1);
            chk(ol_cnt, nl, "output lines");
        end
        // Lines of 16 bytes stay far below the mirror limit
        bus(1, 8'h5c, 32'h2000_0000);
        bus(1, 8'h60, 32'h0000_0000);
        frames(2);
        pv_cnt = 0;
        mir_en = 1;
        frames(1);
        mir_en = 0;
        chk(pv_cnt, N_IL * 16, "mirror pixels");
        tally_and_finish();
    end
endmodule
